// >>> hdl/rpm_sequencer.sv
// module: power state sequencer for the reader front end
// Summary of operation
// - both enables low: everything off except supply_5v_sel_o, which follows bit 0
// - wake only: host supply and auxiliary clock
// - wake rising edge starts regulators and oscillator
// - hold start-up until settled, then switch clock
// - no main enable 100 us after switch: power-down
// - main enable during start-up keeps device active
// - active modes chosen only from control bits
// - bit 7: standby, RF off, 100 us exit
// - bits 7,5,1 clear: RF off, 25 us recovery
// - bit 1 only: receiver powered, transmitter off
// - bit 5 with bit 7 clear: transmitter and receiver powered
`timescale 1ns/1ps
module rpm_sequencer
  import rpm_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = RPM_SLEEP_CYC,
  parameter int unsigned STARTUP_CYC = RPM_STARTUP_CYC,
  parameter int unsigned CONFIRM_CYC = RPM_CONFIRM_CYC,
  parameter int unsigned STBY_EXIT_CYC = RPM_STBY_EXIT_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic main_enable_i,
  input wire logic secondary_wake_pin_i,
  input wire logic regs_settled_i,
  input wire logic osc_stable_i,
  input wire logic [RPM_CTRL_W-1:0] chip_ctrl_i,
  output logic regulator_en_o,
  output logic osc_en_o,
  output logic host_supply_o,
  output logic aux_clk_o,
  output logic hf_clk_o,
  output logic tx_power_o,
  output logic rx_power_o,
  output logic standby_o,
  output logic supply_5v_sel_o
);
  logic main_m_q, main_s_q, wake_m_q, wake_s_q, wake_d1_q;
  logic sett_m_q, sett_s_q, osc_m_q, osc_s_q;
  logic wake_rise, wake_start_q, tmr_done, tmr_load, mode_load;
  logic [RPM_TMR_W-1:0] tmr_val, mode_val;
  rpm_state_t state_q, state_d;
  rpm_mode_t req_mode, target_q, applied_q;

  // input synchronisers
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      {main_m_q, main_s_q, wake_m_q, wake_s_q, wake_d1_q} <= 5'h0;
      {sett_m_q, sett_s_q, osc_m_q, osc_s_q} <= 4'h0;
    end
    else
    begin
      main_m_q <= main_enable_i;
      main_s_q <= main_m_q;
      wake_m_q <= secondary_wake_pin_i;
      wake_s_q <= wake_m_q;
      wake_d1_q <= wake_s_q;
      sett_m_q <= regs_settled_i;
      sett_s_q <= sett_m_q;
      osc_m_q <= osc_stable_i;
      osc_s_q <= osc_m_q;
    end
  end

  assign wake_rise = wake_s_q && !wake_d1_q;

  // regulators and oscillator powered in this state
  function automatic logic rpm_core_on(input rpm_state_t st);
    rpm_core_on = st inside {ST_STARTUP, ST_CONFIRM, ST_ACTIVE};
  endfunction : rpm_core_on

  // requested active mode from control bits
  always_comb
  begin
    if (chip_ctrl_i[RPM_BIT_STANDBY])
      req_mode = MD_STANDBY;
    else if (chip_ctrl_i[RPM_BIT_FULL_RF])
      req_mode = MD_FULL;
    else if (chip_ctrl_i[RPM_BIT_RX_ONLY])
      req_mode = MD_RX_ONLY;
    else
      req_mode = MD_RF_OFF;
  end

  // next state and timer load on entry
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_PD:
      begin
        if (wake_rise || main_s_q)
          state_d = ST_STARTUP;
        else if (wake_s_q)
          state_d = ST_SLEEP_UP;
      end
      ST_SLEEP_UP:
      begin
        if (main_s_q)
          state_d = ST_STARTUP;
        else if (!wake_s_q)
          state_d = ST_PD;
        else if (tmr_done)
          state_d = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (main_s_q)
          state_d = ST_STARTUP;
        else if (!wake_s_q)
          state_d = ST_PD;
      end
      ST_STARTUP:
      begin
        if (!main_s_q && !wake_start_q)
          state_d = ST_PD;
        else if (sett_s_q && osc_s_q && tmr_done)
          state_d = main_s_q ? ST_ACTIVE : ST_CONFIRM;
      end
      ST_CONFIRM:
      begin
        if (main_s_q)
          state_d = ST_ACTIVE;
        else if (tmr_done)
          state_d = ST_PD;
      end
      ST_ACTIVE:
      begin
        if (!main_s_q)
          state_d = wake_s_q ? ST_SLEEP_UP : ST_PD;
      end
      default: state_d = ST_PD;
    endcase
  end

  always_comb
  begin
    case (state_d)
      ST_SLEEP_UP: tmr_val = RPM_TMR_W'(SLEEP_CYC);
      ST_STARTUP: tmr_val = RPM_TMR_W'(STARTUP_CYC);
      ST_CONFIRM: tmr_val = RPM_TMR_W'(CONFIRM_CYC);
      default: tmr_val = '0;
    endcase
  end

  assign mode_load = (state_q == ST_ACTIVE) && (req_mode != target_q);
  assign mode_val = (target_q == MD_STANDBY) ? RPM_TMR_W'(STBY_EXIT_CYC)
    : RPM_TMR_W'(RPM_MODE_STEP_CYC);
  assign tmr_load = (state_d != state_q) || mode_load;

  rpm_timer #(
    .W(RPM_TMR_W)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .load_i(tmr_load),
    .load_val_i((state_d != state_q) ? tmr_val : mode_val),
    .done_o(tmr_done)
  );

  // state register and wake-start memory
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= ST_PD;
      wake_start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q != ST_STARTUP && state_d == ST_STARTUP)
        wake_start_q <= !main_s_q;
    end
  end

  // active mode tracking with transition delay
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      target_q <= MD_RF_OFF;
      applied_q <= MD_RF_OFF;
    end
    else if (state_q != ST_ACTIVE)
    begin
      target_q <= MD_RF_OFF;
      applied_q <= MD_RF_OFF;
    end
    else if (mode_load)
    begin
      target_q <= req_mode;
    end
    else if (tmr_done)
    begin
      applied_q <= target_q;
    end
  end

  // registered outputs
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      {regulator_en_o, osc_en_o, host_supply_o, aux_clk_o, hf_clk_o} <= 5'h0;
      {tx_power_o, rx_power_o, standby_o, supply_5v_sel_o} <= 4'h0;
    end
    else
    begin
      regulator_en_o <= rpm_core_on(state_q);
      osc_en_o <= rpm_core_on(state_q);
      host_supply_o <= state_q != ST_PD;
      aux_clk_o <= state_q inside {ST_SLEEP, ST_STARTUP};
      hf_clk_o <= state_q inside {ST_CONFIRM, ST_ACTIVE};
      tx_power_o <= (state_q == ST_ACTIVE) && (applied_q == MD_FULL);
      rx_power_o <= (state_q == ST_ACTIVE)
        && (applied_q == MD_FULL || applied_q == MD_RX_ONLY);
      standby_o <= (state_q == ST_ACTIVE) && (applied_q == MD_STANDBY);
      supply_5v_sel_o <= chip_ctrl_i[RPM_BIT_SUPPLY_5V];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_pd_all_off: assert property (state_q == ST_PD |=>
    !tx_power_o && !rx_power_o && !host_supply_o && !aux_clk_o && !hf_clk_o)
    else $error("power-down output not off");
  chk_sleep_aux_clk: assert property (state_q == ST_SLEEP |=>
    host_supply_o && aux_clk_o && !hf_clk_o && !tx_power_o && !rx_power_o)
    else $error("sleep outputs wrong");
  chk_wake_edge_start: assert property (state_q == ST_PD && wake_rise |=>
    state_q == ST_STARTUP ##1 regulator_en_o && osc_en_o)
    else $error("wake edge did not start");
  chk_startup_hold: assert property (state_q == ST_STARTUP && !(sett_s_q && osc_s_q)
    |=> state_q != ST_ACTIVE && state_q != ST_CONFIRM)
    else $error("start-up left before settled");
  chk_confirm_timeout: assert property (state_q == ST_CONFIRM && tmr_done && !main_s_q
    |=> state_q == ST_PD ##1 !hf_clk_o)
    else $error("no fall back to power-down");
  chk_main_keeps_on: assert property (state_q == ST_CONFIRM && main_s_q
    |=> state_q == ST_ACTIVE [*2])
    else $error("main enable did not keep active");
  chk_mode_step_hold: assert property (mode_load |=>
    applied_q == $past(applied_q) && target_q == $past(req_mode))
    else $error("mode changed without delay");
  chk_standby_rf_off: assert property (state_q == ST_ACTIVE && applied_q == MD_STANDBY
    |=> standby_o && !tx_power_o && !rx_power_o && hf_clk_o)
    else $error("standby outputs wrong");
  chk_rf_off_mode: assert property (state_q == ST_ACTIVE && applied_q == MD_RF_OFF
    |=> !tx_power_o && !rx_power_o && !standby_o)
    else $error("rf off outputs wrong");
  chk_rx_only_mode: assert property (state_q == ST_ACTIVE && applied_q == MD_RX_ONLY
    |=> rx_power_o && !tx_power_o)
    else $error("receiver only outputs wrong");
  chk_full_rf_mode: assert property (state_q == ST_ACTIVE && applied_q == MD_FULL
    |=> rx_power_o && tx_power_o)
    else $error("full rf outputs wrong");
  chk_supply_select: assert property (1'b1 |=>
    supply_5v_sel_o == $past(chip_ctrl_i[RPM_BIT_SUPPLY_5V]))
    else $error("supply select mismatch");

  cov_wake_to_pd: cover property (state_q == ST_CONFIRM ##1 state_q == ST_PD);
  cov_confirmed: cover property (state_q == ST_CONFIRM ##1 state_q == ST_ACTIVE);
  cov_full_rf: cover property (tx_power_o && rx_power_o);
  cov_sleep: cover property (state_q == ST_SLEEP);
endmodule : rpm_sequencer

// >>> hdl/rpm_pkg.sv
// package: constants and types for the reader power mode sequencer
package rpm_pkg;
  localparam int unsigned RPM_CLK_PERIOD_NS = 8;
  localparam int unsigned RPM_SLEEP_NS = 1500000;
  localparam int unsigned RPM_STARTUP_NS = 4800000;
  localparam int unsigned RPM_CONFIRM_NS = 100000;
  localparam int unsigned RPM_STBY_EXIT_NS = 100000;
  localparam int unsigned RPM_MODE_STEP_NS = 25000;
  localparam int unsigned RPM_SLEEP_CYC =
    (RPM_SLEEP_NS + RPM_CLK_PERIOD_NS - 1) / RPM_CLK_PERIOD_NS;
  localparam int unsigned RPM_STARTUP_CYC =
    (RPM_STARTUP_NS + RPM_CLK_PERIOD_NS - 1) / RPM_CLK_PERIOD_NS;
  localparam int unsigned RPM_CONFIRM_CYC = RPM_CONFIRM_NS / RPM_CLK_PERIOD_NS;
  localparam int unsigned RPM_STBY_EXIT_CYC = RPM_STBY_EXIT_NS / RPM_CLK_PERIOD_NS;
  localparam int unsigned RPM_MODE_STEP_CYC = RPM_MODE_STEP_NS / RPM_CLK_PERIOD_NS;
  localparam int unsigned RPM_TMR_W = 20;
  localparam int unsigned RPM_CTRL_W = 8;
  localparam int unsigned RPM_BIT_STANDBY = 7;
  localparam int unsigned RPM_BIT_FULL_RF = 5;
  localparam int unsigned RPM_BIT_RX_ONLY = 1;
  localparam int unsigned RPM_BIT_SUPPLY_5V = 0;
  typedef enum logic [2:0] {
    ST_PD = 3'h0,
    ST_SLEEP_UP = 3'h1,
    ST_SLEEP = 3'h2,
    ST_STARTUP = 3'h3,
    ST_CONFIRM = 3'h4,
    ST_ACTIVE = 3'h5
  } rpm_state_t;
  typedef enum logic [1:0] {
    MD_RF_OFF = 2'h0,
    MD_RX_ONLY = 2'h1,
    MD_FULL = 2'h2,
    MD_STANDBY = 2'h3
  } rpm_mode_t;
endpackage : rpm_pkg

// >>> hdl/rpm_timer.sv
// module: loadable down counter for sequencer delays
`timescale 1ns/1ps
module rpm_timer #(
  parameter int unsigned W = 20
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q <= '0;
    end
    else if (load_i)
    begin
      cnt_q <= load_val_i;
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign done_o = (cnt_q == '0);
endmodule : rpm_timer

// >>> tb/rpm_host_model.sv
// host model: drives both enable pins with enforced spacing
`timescale 1ns/1ps
module rpm_host_model #(
  parameter int unsigned SPACE_CYC = 40
) (
  input wire logic core_clk_i,
  output logic main_enable_o,
  output logic wake_o
);
  int unsigned idle_q;
  initial
  begin
    main_enable_o = 1'b0;
    wake_o = 1'b0;
    idle_q = 0;
  end
  always @(posedge core_clk_i) idle_q <= idle_q + 1;
  // one pin at a time, after the spacing has run out
  task automatic drive(input bit to_main, input logic v);
    while (idle_q < SPACE_CYC) @(negedge core_clk_i);
    if (to_main) main_enable_o = v;
    else wake_o = v;
    idle_q = 0;
  endtask : drive
endmodule : rpm_host_model

// >>> tb/tb_top.sv
// testbench: pins, control bits and mode walk of the sequencer
`timescale 1ns/1ps
module tb_top;
  import rpm_pkg::*;
  localparam int CONF = 15;
  typedef struct packed {logic [7:0] ctrl; logic [3:0] exp;} rpm_row_t;
  rpm_row_t rows [7] = '{'{8'h21, 4'hD}, '{8'h30, 4'hC}, '{8'h03, 4'h5}, '{8'h02, 4'h4},
    '{8'h01, 4'h1}, '{8'h00, 4'h0}, '{8'h81, 4'h3}};
  logic clk, rst_n, settled, stable, en, wake;
  logic [RPM_CTRL_W-1:0] ctrl;
  wire [8:0] outs;
  logic [3:0] prev;
  int bad_count, n_compared, cyc, n;
  rpm_host_model u_rpm_host_model (.core_clk_i(clk), .main_enable_o(en), .wake_o(wake));
  rpm_sequencer #(.SLEEP_CYC(20), .STARTUP_CYC(30), .CONFIRM_CYC(CONF), .STBY_EXIT_CYC(15))
  u_rpm_sequencer (.core_clk_i(clk), .reset_n_i(rst_n), .main_enable_i(en),
    .secondary_wake_pin_i(wake), .regs_settled_i(settled), .osc_stable_i(stable),
    .chip_ctrl_i(ctrl), .regulator_en_o(outs[8]), .osc_en_o(outs[7]),
    .host_supply_o(outs[6]), .aux_clk_o(outs[5]), .hf_clk_o(outs[4]), .tx_power_o(outs[3]),
    .rx_power_o(outs[2]), .standby_o(outs[1]), .supply_5v_sel_o(outs[0]));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic finish_test;
    $display("compared %0d, bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] msk);
    n_compared++;
    if ((outs & msk) !== (exp & msk))
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp & msk, outs & msk);
    end
  endtask : chk
  task automatic chk_rng(input string what, input int lo, input int hi);
    n_compared++;
    if (n < lo || n > hi)
    begin
      bad_count++;
      $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, n);
    end
  endtask : chk_rng
  task automatic wait_bit(input int idx, input logic v, input int lim);
    n = 0;
    while (outs[idx] !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_bit
  initial
  begin
    rst_n = 1'b0;
    settled = 1'b0;
    stable = 1'b0;
    ctrl = 8'h00;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk("reset", 9'h000, 9'h1FF);
    $display("test reset done");
    u_rpm_host_model.drive(1'b0, 1'b1);
    repeat (40) @(negedge clk);
    stable = 1'b1;
    chk("start-up", 9'h1E0, 9'h1FC);
    settled = 1'b1;
    wait_bit(4, 1'b1, 40);
    chk("clock switch", 9'h010, 9'h030);
    wait_bit(4, 1'b0, 100);
    chk_rng("confirm window", CONF - 2, CONF + 4);
    repeat (40) @(negedge clk);
    chk("sleep", 9'h060, 9'h07C);
    $display("test wake start done");
    u_rpm_host_model.drive(1'b1, 1'b1);
    wait_bit(4, 1'b1, 100);
    repeat (3 * CONF) @(negedge clk);
    chk("stay active", 9'h010, 9'h010);
    prev = 4'h0;
    foreach (rows[i])
    begin
      ctrl = rows[i].ctrl;
      repeat (RPM_MODE_STEP_CYC - 20) @(negedge clk);
      chk("mode held", {5'h01, prev}, 9'h01E);
      repeat (40) @(negedge clk);
      chk("mode set", {5'h01, rows[i].exp}, 9'h01F);
      prev = rows[i].exp;
    end
    $display("test mode table done");
    ctrl = 8'h80;
    repeat (5) @(negedge clk);
    ctrl = 8'h20;
    wait_bit(3, 1'b1, 200);
    chk_rng("standby exit", 12, 25);
    $display("test standby exit done");
    u_rpm_host_model.drive(1'b1, 1'b0);
    repeat (60) @(negedge clk);
    chk("back to sleep", 9'h060, 9'h07C);
    ctrl = 8'h00;
    u_rpm_host_model.drive(1'b0, 1'b0);
    repeat (10) @(negedge clk);
    chk("power-down", 9'h000, 9'h1FF);
    $display("test fall back done");
    settled = 1'b0;
    u_rpm_host_model.drive(1'b1, 1'b1);
    repeat (38) @(negedge clk);
    chk("held unsettled", 9'h000, 9'h010);
    u_rpm_host_model.drive(1'b1, 1'b0);
    repeat (10) @(negedge clk);
    chk("abort start", 9'h000, 9'h1FF);
    $display("test abort done");
    u_rpm_host_model.drive(1'b0, 1'b1);
    repeat (40) @(negedge clk);
    settled = 1'b1;
    wait_bit(4, 1'b1, 40);
    u_rpm_host_model.drive(1'b1, 1'b1);
    repeat (3 * CONF) @(negedge clk);
    chk("confirmed", 9'h1D0, 9'h1FF);
    $display("test confirm done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("mid-run reset", 9'h000, 9'h1FF);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("after release", 9'h000, 9'h1FF);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : tb_top
